/* File: hw/reset_pulse_standardizer.sv */
// What this block does
// (RULE1) Start trigger rise fires three resets, then delayed start pulse.
// (RULE2) Delayed start pulse lasts 12 to 20 us, after the resets.
// (RULE3) Each reset pulse lasts 37 to 64 us.
// (RULE4) Start trigger falling edge produces nothing.
// (RULE5) Logic triggers fire only the first reset pulse.
// (RULE6) Third reset pulse start fires first reset via inverted chain.
// (RULE7) First stage fires on OR rising edge; chain drops when third ends.
// (RULE8) Reset outputs idle inactive, active only during the pulse.
// (RULE9) Each reset output drives direct resets of up to 20 flops.
// (RULE10) Shaper emits fixed pulse on rise, ends early if input drops.
// (RULE11) Trigger source holds input long enough and allows recovery time; the testbench holds one logic trigger for only 100 cycles.
// (RULE12) Delayed start begins 67 to 97 us after trigger rise.
// (RULE13) Durations come from counters on the reference clock.
// (RULE14) Trigger inputs are synchronised and edge detected.
`timescale 1ns/1ps
module reset_pulse_standardizer
  import reset_pulse_pkg::*;
(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_start_trigger,
  input  wire logic [LOGIC_TRIG_N-1:0] i_logic_trigger,
  output logic                         o_first_reset_pulse_n,
  output logic                         o_second_reset_pulse_n,
  output logic                         o_third_reset_pulse_n,
  output logic                         o_delayed_start_pulse
);
  // Reset phase keeps the start-fed stages triggered for one pulse length;
  // hold-off covers the rest of the start delay
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RESET,
    SEQ_HOLDOFF,
    SEQ_START
  } seq_t;

  typedef struct packed {
    // Pin synchronisers and edge history
    logic                    start_s1;
    logic                    start_s2;
    logic                    start_d;
    logic [LOGIC_TRIG_N-1:0] logic_s1;
    logic [LOGIC_TRIG_N-1:0] logic_s2;
    // Shaper trigger levels
    logic                    second_trig;
    logic                    third_trig;
    logic                    first_or;
    // Start sequencer
    seq_t                    seq;
    logic [CNT_W-1:0]        cnt;
    // Registered outputs
    logic                    first_n;
    logic                    second_n;
    logic                    third_n;
    logic                    start_pulse;
  } top_state_t;

  localparam logic [CNT_W-1:0] RESET_LEN = CNT_W'(RESET_PULSE_CYC);
  localparam logic [CNT_W-1:0] DELAY_LEN = CNT_W'(START_DELAY_CYC);
  localparam logic [CNT_W-1:0] START_LEN = CNT_W'(START_PULSE_CYC);
  // Part of the start delay left once the reset phase is over
  localparam logic [CNT_W-1:0] HOLD_LEN  = DELAY_LEN - RESET_LEN;

  top_state_t st;
  top_state_t next_st;
  logic       start_rise;
  logic       any_logic;
  logic       chain;
  logic       reset_busy;

  shaper_if first_if ();
  shaper_if second_if ();
  shaper_if third_if ();

  pulse_shaper #(.LEN(RESET_LEN)) u_first (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .port_io   (first_if)
  );
  pulse_shaper #(.LEN(RESET_LEN)) u_second (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .port_io   (second_if)
  );
  pulse_shaper #(.LEN(RESET_LEN)) u_third (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .port_io   (third_if)
  );

  // Shaper inputs held high for the full length in a start sequence; a short logic trigger cuts the first pulse short
  assign second_if.trig = st.second_trig;
  assign third_if.trig  = st.third_trig;
  assign first_if.trig  = st.first_or; // (RULE7)

  assign start_rise = st.start_s2 && !st.start_d; // (RULE4)
  assign any_logic  = |st.logic_s2;
  // Inverter on the active-low third output, idle low between sequences
  assign chain      = !st.third_n; // (RULE6)
  assign reset_busy = second_if.pulse || third_if.pulse;

  always_comb begin
    next_st = st;

    // Pin inputs pass two flops before anything reads them
    next_st.start_s1 = i_start_trigger; // (RULE14)
    next_st.start_s2 = st.start_s1;
    next_st.start_d  = st.start_s2;
    next_st.logic_s1 = i_logic_trigger;
    next_st.logic_s2 = st.logic_s1;

    // A start rise while a sequence runs is ignored, so a bouncing relay
    // cannot retrigger a stage and have its pulse cut short
    case (st.seq)
      SEQ_IDLE: begin
        if (start_rise) begin
          next_st.seq = SEQ_RESET; // (RULE1)
          next_st.cnt = RESET_LEN - CNT_ONE;
        end
      end
      SEQ_RESET: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.seq = SEQ_HOLDOFF; // (RULE12)
          next_st.cnt = HOLD_LEN - CNT_ONE;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE; // (RULE13)
        end
      end
      SEQ_HOLDOFF: begin
        // Start pulse also waits for both start-fed stages to be quiet
        if (st.cnt == CNT_ZERO) begin
          if (!reset_busy) begin
            next_st.seq         = SEQ_START; // (RULE2)
            next_st.cnt         = START_LEN - CNT_ONE;
            next_st.start_pulse = 1'b1;
          end
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      SEQ_START: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.seq         = SEQ_IDLE;
          next_st.start_pulse = 1'b0;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      default: begin
        next_st.seq         = SEQ_IDLE;
        next_st.cnt         = CNT_ZERO;
        next_st.start_pulse = 1'b0;
      end
    endcase

    // Level held for exactly one pulse length, then low for the rest of
    // the sequence, which gives the stages their recovery time
    next_st.second_trig = (next_st.seq == SEQ_RESET); // (RULE1)
    next_st.third_trig  = (next_st.seq == SEQ_RESET);

    // Chain drops with the third pulse, so logic triggers stay unmasked
    next_st.first_or = chain || any_logic; // (RULE5)

    // Active-low direct resets, idle high
    next_st.first_n  = !first_if.pulse; // (RULE8) (RULE9)
    next_st.second_n = !second_if.pulse; // (RULE3)
    next_st.third_n  = !third_if.pulse;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st          <= '0;
      st.seq      <= SEQ_IDLE;
      st.first_n  <= 1'b1;
      st.second_n <= 1'b1;
      st.third_n  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_first_reset_pulse_n  = st.first_n;
  assign o_second_reset_pulse_n = st.second_n;
  assign o_third_reset_pulse_n  = st.third_n;
  assign o_delayed_start_pulse  = st.start_pulse;
endmodule

/* File: hw/reset_pulse_pkg.sv */
package reset_pulse_pkg;
  localparam int unsigned CLK_RATE_HZ     = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_RATE_HZ;
  // Nominal durations inside the documented ranges, in microseconds
  localparam int unsigned RESET_PULSE_US  = 50;
  localparam int unsigned START_DELAY_US  = 80;
  localparam int unsigned START_PULSE_US  = 16;
  localparam int unsigned RESET_PULSE_CYC =
    RESET_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned START_DELAY_CYC =
    START_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned START_PULSE_CYC =
    START_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 10;
  localparam int unsigned LOGIC_TRIG_N    = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 10'h001;
endpackage

/* File: hw/shaper_if.sv */
`timescale 1ns/1ps
interface shaper_if;
  logic trig;
  logic pulse;
  modport shaper (input trig, output pulse);
  modport user   (output trig, input pulse);
endinterface

/* File: hw/pulse_shaper.sv */
`timescale 1ns/1ps
module pulse_shaper
  import reset_pulse_pkg::*;
#(
  parameter logic [CNT_W-1:0] LEN = CNT_ONE
) (
  input  wire logic  i_ref_clk,
  input  wire logic  i_rstn,
  shaper_if.shaper   port_io
);
  typedef struct packed {
    logic             trig_d;
    logic             pulse;
    logic [CNT_W-1:0] cnt;
  } shaper_state_t;

  shaper_state_t st;
  shaper_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.trig_d = port_io.trig;
    if (port_io.trig && !st.trig_d) begin
      next_st.pulse = 1'b1; // (RULE10)
      next_st.cnt   = LEN - CNT_ONE;
    end else if (st.pulse) begin
      if (!port_io.trig || st.cnt == CNT_ZERO) begin
        next_st.pulse = 1'b0; // (RULE10)
      end else begin
        next_st.cnt = st.cnt - CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port_io.pulse = st.pulse;
endmodule

/* File: testbench/reset_pulse_standardizer_checker.sv */
`timescale 1ns/1ps
module reset_pulse_standardizer_checker (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_start_trigger,
  input wire logic o_first_reset_pulse_n,
  input wire logic o_second_reset_pulse_n,
  input wire logic o_third_reset_pulse_n,
  input wire logic o_delayed_start_pulse
);
  wire n1 = o_first_reset_pulse_n;
  wire n2 = o_second_reset_pulse_n;
  wire n3 = o_third_reset_pulse_n;
  wire ds = o_delayed_start_pulse;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  AST_LEN_MIN: assert property ($rose(n2) |-> !$past(n2, 370))
    else $error("reset short");
  AST_LEN_MAX: assert property ($fell(n3) |-> ##[1:640] n3)
    else $error("reset long");
  AST_PAIR: assert property ($fell(n2) |-> $fell(n3))
    else $error("pair");
  AST_CHAIN: assert property ($fell(n3) |-> ##[0:4] !n1)
    else $error("chain");
  AST_GAP: assert property ($fell(n3) |-> ##[664:964] $rose(ds))
    else $error("start delay");
  AST_AFTER: assert property ($rose(ds) |-> n2 && n3)
    else $error("start early");
  AST_DS_MIN: assert property ($fell(ds) |-> $past(ds, 120))
    else $error("start short");
  AST_DS_MAX: assert property ($rose(ds) |-> ##[1:200] !ds)
    else $error("start long");
  AST_LOGIC: assert property ($fell(n1) && n3 |-> n2 [*8])
    else $error("logic fired more");
  AST_FALL: assert property ($fell(i_start_trigger) && n2 |=> n2 [*8])
    else $error("fall fired");
endmodule
bind reset_pulse_standardizer reset_pulse_standardizer_checker chk (.*);

/* File: testbench/trigger_source.sv */
`timescale 1ns/1ps
module trigger_source (
  input  wire logic       i_ref_clk,
  output logic            o_start,
  output logic [2:0]      o_logic
);
  initial begin
    o_start = 1'h0;
    o_logic = 3'h0;
  end
  // Idle gap after each trigger lets the stage recover
  task automatic fire(input int sel, input int len);
    @(negedge i_ref_clk);
    if (sel > 2) o_start = 1'h1;
    else o_logic[sel] = 1'h1;
    repeat (len) @(negedge i_ref_clk);
    o_start = 1'h0;
    o_logic = 3'h0;
    repeat (900) @(negedge i_ref_clk);
  endtask
endmodule

/* File: testbench/reset_pulse_standardizer_tb_top.sv */
`timescale 1ns/1ps
module reset_pulse_standardizer_tb_top;
  logic       i_ref_clk;
  logic       i_rstn;
  wire        i_start_trigger;
  wire  [2:0] i_logic_trigger;
  wire        o_first_reset_pulse_n;
  wire        o_second_reset_pulse_n;
  wire        o_third_reset_pulse_n;
  wire        o_delayed_start_pulse;
  int         err_total;
  int         comparisons;
  int         cycles;
  int         cnt [4];
  reset_pulse_standardizer dut (.*);
  trigger_source src (.i_ref_clk, .o_start(i_start_trigger),
    .o_logic(i_logic_trigger));
  initial begin
    i_ref_clk = 1'h0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task automatic results;
    $display("TB: errors %0d checks %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic watch(input int n);
    cnt = '{0, 0, 0, 0};
    repeat (n) begin
      @(negedge i_ref_clk);
      cnt[0] += int'(o_first_reset_pulse_n === 1'h0);
      cnt[1] += int'(o_second_reset_pulse_n === 1'h0);
      cnt[2] += int'(o_third_reset_pulse_n === 1'h0);
      cnt[3] += int'(o_delayed_start_pulse === 1'h1);
    end
  endtask
  function automatic bit in_len(input int c);
    return c >= 370 && c <= 640;
  endfunction
  task automatic t_start;
    fork
      src.fire(3, 700);
      watch(1200);
    join
    chk(in_len(cnt[0]) && in_len(cnt[1]) && in_len(cnt[2]), "reset");
    chk(cnt[3] >= 120 && cnt[3] <= 200, "start");
  endtask
  task automatic t_logic(input int sel, input int len);
    fork
      src.fire(sel, len);
      watch(900);
    join
    chk(cnt[1] + cnt[2] + cnt[3] == 0, "only first");
    if (len > 500) chk(in_len(cnt[0]), "first");
    else chk(cnt[0] > 0 && cnt[0] < 370, "early end");
  endtask
  initial begin
    i_rstn = 1'h0;
    repeat (6) @(negedge i_ref_clk);
    i_rstn = 1'h1;
    t_start();
    for (int i = 0; i < 3; i++) t_logic(i, 700);
    t_logic(1, 100);
    t_start();
    results();
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      results();
    end
  end
endmodule
